// >>> verilog/ramp_defines.svh
// constants for the speed setpoint limiter and ramp block
// assumes a 50 MHz system clock and a 1 ms ramp tick
`ifndef RAMP_DEFINES_SVH
`define RAMP_DEFINES_SVH
`define CLK_PERIOD_NS 20
`define TICK_US 1000
`define TICK_CYC (`TICK_US * 1000 / `CLK_PERIOD_NS)
`define BANDS 4
`define OFS_CTRL 8'h00
`define OFS_MIN 8'h04
`define OFS_MAX 8'h08
`define OFS_POSLIM 8'h0C
`define OFS_NEGLIM 8'h10
`define OFS_UPMS 8'h14
`define OFS_DNMS 8'h18
`define OFS_IRMS 8'h1C
`define OFS_FRMS 8'h20
`define OFS_QSMS 8'h24
`define OFS_QSIR 8'h28
`define OFS_QSFR 8'h2C
`define OFS_UPSCL 8'h30
`define OFS_DNSCL 8'h34
`define OFS_STAT 8'h38
`define OFS_OUT 8'h3C
`define OFS_BAND 8'h40
`define OFS_END 8'h60
`define B_RTYPE 0
`define B_RND 1
`define B_MINSRC 2
`define B_POSSRC 3
`define B_NEGSRC 4
`define B_UPSRC 5
`define B_DNSRC 6
`define B_OVFLT 7
`define B_BRKFLT 8
`define S_OVALM 0
`define S_OVFLT 1
`define S_BRFLT 2
`define S_QS 3
`define S_BUSY 4
`define S_LAG 5
`define CTRL_RST 32'h0000_0001
`define MAX_RST 32'h0000_05DC
`define POSLIM_RST 32'h0003_3450
`define NEGLIM_RST 32'hFFFC_CBB0
`define RAMP_MS_RST 32'h0000_2710
`define SCALE_RST 32'h0000_0100
`define SCALE_SHIFT 8
`define FRAC 16
`endif

// >>> verilog/ramp_pkg.sv
// types shared by the speed setpoint limiter and ramp block
// assumes ramp_defines.svh is on the include path
`include "ramp_defines.svh"
package ramp_pkg;
   typedef logic signed [63:0] s64_t;
   typedef logic signed [127:0] s128_t;
   typedef enum {RP_IDLE, RP_RAMP, RP_QSTOP} rphase_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
   typedef struct packed {
      logic [31:0] ctrl, minSp, maxSp, posLim, negLim, upMs, dnMs, irMs, frMs;
      logic [31:0] qsMs, qsIr, qsFr, upScl, dnScl;
      logic [`BANDS-1:0][31:0] bLo;
      logic [`BANDS-1:0][31:0] bHi;
      logic [2:0] qsS, clS, dcS;
      logic qs, cl, dc;
      logic [31:0] div;
      s64_t pos;
      s64_t acc;
      logic [31:0] outSp;
      logic ovAlarm, ovFault, brFault, lag;
      rphase_t ph;
      apb_rsp_t rsp;
   } st_t;
endpackage

// >>> verilog/speed_setpoint_limiter_ramp.sv
// speed setpoint limiter with skip bands and basic/extended ramp
// assumes an apb master on clk_sys and setpoint sources on the same clock
//
// Overview of operation
// - four skip bands; setpoint may pass through a band but never rests in it
// - steady setpoint magnitude kept at or above minimum speed except in quick stop, default zero
// - speeds below minimum occur only while the ramp passes through them or in quick stop
// - minimum speed taken from register or dynamic input, select default zero
// - setpoint clamped to maximum speed both ways, default 1500 rpm
// - over-speed message, alarm or fault, when actual speed exceeds maximum
// - separate positive and negative limits from selectable sources, +-210000 rpm
// - ramp stage limits how fast the effective setpoint changes
// - ramp type select: 0 basic, 1 extended, default extended
// - extended limits acceleration and jerk; basic limits acceleration only
// - basic type ignores rounding times and ramps linearly
// - ramp-up time, default 10 s, is zero to maximum speed
// - ramp-down time, default 10 s, maximum to standstill, set independently
// - extended ramps grow by half the sum of the rounding times
// - one initial and one final rounding time for both directions, default 0
// - rounding type: 0 continuous, 1 discontinuous smoothing, default 0
// - quick stop brakes with its own ramp-down time, default 0 s
// - quick stop uses its own rounding times in extended type
// - ramp-up and ramp-down times scaled by selectable factors, default one
// - at current limit while accelerating the actual speed lags the ramp
// - braking past capability either stretches braking or raises a fault
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module speed_setpoint_limiter_ramp
   import ramp_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register bus
   input wire apb_req_t apbReq,
   output apb_rsp_t apbRsp,
   // setpoint sources, same clock
   input wire logic [31:0] setpointIn,
   input wire logic [31:0] minSpeedDyn,
   input wire logic [31:0] posLimDyn,
   input wire logic [31:0] negLimDyn,
   input wire logic [31:0] upScaleDyn,
   input wire logic [31:0] dnScaleDyn,
   // feedback from motor control, same clock
   input wire logic [31:0] actualSpeed,
   // pins
   input wire logic quickStopCmd,
   input wire logic currentLimit,
   input wire logic dcLinkHigh,
   // to motor control
   output logic [31:0] rampedSetpoint,
   output logic overSpeedAlarm,
   output logic overSpeedFault,
   output logic brakeFault
);

   if (TICK_CYCLES < 2) begin : g_badTick
      $error("TICK_CYCLES must be at least 2");
   end

   logic [1:0] rstSync_r;
   logic rstn;
   st_t st_r;
   st_t st_nxt;

   // reset is released through two flops so every flop leaves reset on one edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstSync_r <= 2'b00;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstn = rstSync_r[1];

   // shared by the read and write paths: {aligned and in range, word index}
   function automatic logic [5:0] decode(input logic [7:0] a);
      logic ok;
      ok = (a[1:0] == 2'b00) && (a < `OFS_END);
      return {ok, a[6:2]};
   endfunction

   function automatic s64_t sx(input logic [31:0] v);
      return s64_t'($signed(v));
   endfunction

   function automatic s64_t zx(input logic [31:0] v);
      return s64_t'({32'h0000_0000, v});
   endfunction

   function automatic s64_t mag(input s64_t v);
      return (v < 0) ? -v : v;
   endfunction

   function automatic s64_t atLeast1(input s64_t v);
      return (v < 1) ? 64'sd1 : v;
   endfunction

   always_comb begin
      logic [5:0] dec;
      logic access;
      logic tick;
      logic up;
      logic frz;
      logic ext;
      logic [31:0] rd;
      s64_t sp, m, lo, hi, lim, mn, tgt, err, tms, scl, sms, aMax, ji, jf;
      s64_t ir, fr, a, dir, step, np;
      s128_t aa, dd;
      dec = 6'h00;
      access = 1'b0;
      tick = 1'b0;
      up = 1'b0;
      frz = 1'b0;
      ext = 1'b0;
      rd = 32'h0000_0000;
      sp = '0;
      m = '0;
      lo = '0;
      hi = '0;
      lim = '0;
      mn = '0;
      tgt = '0;
      err = '0;
      tms = '0;
      scl = '0;
      sms = '0;
      aMax = '0;
      ji = '0;
      jf = '0;
      ir = '0;
      fr = '0;
      a = '0;
      dir = '0;
      step = '0;
      np = '0;
      aa = '0;
      dd = '0;
      st_nxt = st_r;

      // pins: three flops, a change counts once the last two agree
      st_nxt.qsS = {st_r.qsS[1:0], quickStopCmd};
      st_nxt.clS = {st_r.clS[1:0], currentLimit};
      st_nxt.dcS = {st_r.dcS[1:0], dcLinkHigh};
      if (st_r.qsS[1] == st_r.qsS[2]) st_nxt.qs = st_r.qsS[2];
      if (st_r.clS[1] == st_r.clS[2]) st_nxt.cl = st_r.clS[2];
      if (st_r.dcS[1] == st_r.dcS[2]) st_nxt.dc = st_r.dcS[2];

      // register bus: one wait state, write lands on the pready edge
      access = apbReq.psel && apbReq.penable;
      dec = decode(apbReq.paddr);
      st_nxt.rsp.pready = 1'b0;
      st_nxt.rsp.pslverr = 1'b0;
      if (access && !st_r.rsp.pready) begin
         case ({dec[4:0], 2'b00})
            `OFS_CTRL: rd = st_r.ctrl;
            `OFS_MIN: rd = st_r.minSp;
            `OFS_MAX: rd = st_r.maxSp;
            `OFS_POSLIM: rd = st_r.posLim;
            `OFS_NEGLIM: rd = st_r.negLim;
            `OFS_UPMS: rd = st_r.upMs;
            `OFS_DNMS: rd = st_r.dnMs;
            `OFS_IRMS: rd = st_r.irMs;
            `OFS_FRMS: rd = st_r.frMs;
            `OFS_QSMS: rd = st_r.qsMs;
            `OFS_QSIR: rd = st_r.qsIr;
            `OFS_QSFR: rd = st_r.qsFr;
            `OFS_UPSCL: rd = st_r.upScl;
            `OFS_DNSCL: rd = st_r.dnScl;
            `OFS_STAT: begin
               rd[`S_OVALM] = st_r.ovAlarm;
               rd[`S_OVFLT] = st_r.ovFault;
               rd[`S_BRFLT] = st_r.brFault;
               rd[`S_QS] = st_r.qs;
               rd[`S_BUSY] = (st_r.ph != RP_IDLE);
               rd[`S_LAG] = st_r.lag;
            end
            `OFS_OUT: rd = st_r.outSp;
            default: begin
               // band words sit above the last named register: index bit 4 marks them
               if (dec[4]) begin
                  rd = dec[0] ? st_r.bHi[dec[2:1]] : st_r.bLo[dec[2:1]];
               end
            end
         endcase
         st_nxt.rsp.pready = 1'b1;
         st_nxt.rsp.pslverr = !dec[5];
         st_nxt.rsp.prdata = dec[5] ? rd : 32'h0000_0000;
      end
      if (access && st_r.rsp.pready && apbReq.pwrite && dec[5]) begin
         case ({dec[4:0], 2'b00})
            `OFS_CTRL: st_nxt.ctrl = apbReq.pwdata;
            `OFS_MIN: st_nxt.minSp = apbReq.pwdata;
            `OFS_MAX: st_nxt.maxSp = apbReq.pwdata;
            `OFS_POSLIM: st_nxt.posLim = apbReq.pwdata;
            `OFS_NEGLIM: st_nxt.negLim = apbReq.pwdata;
            `OFS_UPMS: st_nxt.upMs = apbReq.pwdata;
            `OFS_DNMS: st_nxt.dnMs = apbReq.pwdata;
            `OFS_IRMS: st_nxt.irMs = apbReq.pwdata;
            `OFS_FRMS: st_nxt.frMs = apbReq.pwdata;
            `OFS_QSMS: st_nxt.qsMs = apbReq.pwdata;
            `OFS_QSIR: st_nxt.qsIr = apbReq.pwdata;
            `OFS_QSFR: st_nxt.qsFr = apbReq.pwdata;
            `OFS_UPSCL: st_nxt.upScl = apbReq.pwdata;
            `OFS_DNSCL: st_nxt.dnScl = apbReq.pwdata;
            `OFS_STAT: begin
               // write one to clear; a fresh event below still wins
               if (apbReq.pwdata[`S_OVFLT]) begin
                  st_nxt.ovFault = 1'b0;
               end
               if (apbReq.pwdata[`S_BRFLT]) begin
                  st_nxt.brFault = 1'b0;
               end
            end
            default: begin
               if (dec[4]) begin
                  if (dec[0]) begin
                     st_nxt.bHi[dec[2:1]] = apbReq.pwdata;
                  end else begin
                     st_nxt.bLo[dec[2:1]] = apbReq.pwdata;
                  end
               end
            end
         endcase
      end

      // over-speed message
      st_nxt.ovAlarm = mag(sx(actualSpeed)) > sx(st_r.maxSp);
      if (st_nxt.ovAlarm && st_r.ctrl[`B_OVFLT]) st_nxt.ovFault = 1'b1;

      // setpoint conditioning: skip bands, limits, minimum speed
      sp = sx(setpointIn);
      m = mag(sp);
      for (int i = 0; i < `BANDS; i++) begin
         lo = zx(st_r.bLo[i]);
         hi = zx(st_r.bHi[i]);
         // a band with lo >= hi is off; inside a band jump to the nearer edge
         if (m > lo && m < hi) m = ((m - lo) < (hi - m)) ? lo : hi;
      end
      sp = (sp < 0) ? -m : m;
      if (sp > sx(st_r.maxSp)) sp = sx(st_r.maxSp);
      if (sp < -sx(st_r.maxSp)) sp = -sx(st_r.maxSp);
      lim = st_r.ctrl[`B_POSSRC] ? sx(posLimDyn) : sx(st_r.posLim);
      if (sp > lim) sp = lim;
      lim = st_r.ctrl[`B_NEGSRC] ? sx(negLimDyn) : sx(st_r.negLim);
      if (sp < lim) sp = lim;
      mn = st_r.ctrl[`B_MINSRC] ? sx(minSpeedDyn) : sx(st_r.minSp);
      mn = mag(mn);
      // only the target is raised; the ramp itself still crosses the region
      if (mag(sp) < mn) sp = (sp < 0) ? -mn : mn;
      if (st_r.qs) sp = '0;

      // ramp generator
      tgt = sp <<< `FRAC;
      err = tgt - st_r.pos;
      up = (err > 0 && st_r.pos >= 0) || (err < 0 && st_r.pos <= 0);
      ext = st_r.ctrl[`B_RTYPE];
      if (st_r.qs) begin
         tms = zx(st_r.qsMs);
         ir = zx(st_r.qsIr);
         fr = zx(st_r.qsFr);
      end else begin
         tms = up ? zx(st_r.upMs) : zx(st_r.dnMs);
         ir = zx(st_r.irMs);
         fr = zx(st_r.frMs);
      end
      if (up && !st_r.qs) begin
         scl = st_r.ctrl[`B_UPSRC] ? zx(upScaleDyn) : zx(st_r.upScl);
      end else begin
         scl = st_r.ctrl[`B_DNSRC] ? zx(dnScaleDyn) : zx(st_r.dnScl);
      end
      sms = atLeast1((tms * scl) >>> `SCALE_SHIFT);
      aMax = atLeast1((sx(st_r.maxSp) <<< `FRAC) / sms);
      // reaching aMax over the rounding time adds half of it to the ramp
      ji = atLeast1(aMax / atLeast1(ir));
      jf = atLeast1(aMax / atLeast1(fr));
      dir = (err > 0) ? 64'sd1 : -64'sd1;
      if (ext) begin
         a = st_r.acc;
         if (st_r.ctrl[`B_RND] && (a * dir) < 0) a = '0;
         aa = s128_t'(a) * s128_t'(a);
         dd = s128_t'(2) * s128_t'(jf) * s128_t'(mag(err));
         if ((a * dir) > 0 && aa >= dd) begin
            a = (mag(a) <= jf) ? '0 : a - dir * jf;
         end else begin
            a = a + dir * ji;
            if (mag(a) > aMax) a = dir * aMax;
         end
         step = a;
      end else begin
         step = dir * aMax;
         a = '0;
      end
      // braking near the drive's capability
      // freezing stretches the real braking time instead of tripping the drive
      if (!up && err != 0 && (st_r.cl || st_r.dc)) begin
         if (st_r.ctrl[`B_BRKFLT]) st_nxt.brFault = 1'b1;
         else frz = 1'b1;
      end
      // acceleration in current limit: the ramp keeps going, the motor lags
      st_nxt.lag = up && err != 0 && st_r.cl;

      // divider gives the ramp tick
      tick = (st_r.div == 32'(TICK_CYCLES - 1));
      st_nxt.div = tick ? 32'h0000_0000 : st_r.div + 32'h0000_0001;
      if (tick && !frz) begin
         if (mag(err) <= mag(step) || (ext && mag(err) <= jf && mag(a) <= jf)) begin
            np = tgt;
            a = '0;
         end else begin
            np = st_r.pos + step;
         end
         st_nxt.pos = np;
         st_nxt.acc = a;
         st_nxt.outSp = np[`FRAC+31:`FRAC];
      end

      case (st_r.ph)
         RP_IDLE: begin
            if (err != 0) st_nxt.ph = st_r.qs ? RP_QSTOP : RP_RAMP;
         end
         RP_RAMP: begin
            if (err == 0) st_nxt.ph = RP_IDLE;
            else if (st_r.qs) st_nxt.ph = RP_QSTOP;
         end
         RP_QSTOP: begin
            if (err == 0) st_nxt.ph = RP_IDLE;
         end
         default: begin
            st_nxt.ph = RP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.ctrl <= `CTRL_RST;
         st_r.maxSp <= `MAX_RST;
         st_r.posLim <= `POSLIM_RST;
         st_r.negLim <= `NEGLIM_RST;
         st_r.upMs <= `RAMP_MS_RST;
         st_r.dnMs <= `RAMP_MS_RST;
         st_r.upScl <= `SCALE_RST;
         st_r.dnScl <= `SCALE_RST;
         st_r.ph <= RP_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apbRsp = st_r.rsp;
   assign rampedSetpoint = st_r.outSp;
   assign overSpeedAlarm = st_r.ovAlarm;
   assign overSpeedFault = st_r.ovFault;
   assign brakeFault = st_r.brFault;

endmodule // speed_setpoint_limiter_ramp

// >>> dv/motor_model.sv
// behavioural motor control stage: actual speed follows the ramped setpoint
// assumes the limiter's clk_sys; an offset lets a test push the speed past maximum
`timescale 1ns/1ps
module motor_model (
   // clock
   input wire logic clk_sys,
   // from the limiter
   input wire logic [31:0] rampedSetpoint,
   // test control
   input wire logic [31:0] spdOffset,
   // to the limiter
   output logic [31:0] actualSpeed = '0
);
   // one cycle lag stands in for the mechanics; current-limit lag is not modelled
   always_ff @(posedge clk_sys) begin
      actualSpeed <= rampedSetpoint + spdOffset;
   end
endmodule // motor_model

// >>> dv/ramp_checker.sv
// port-level checks on the speed setpoint limiter and ramp
// assumes it is bound onto the limiter's top module, one clock domain
`timescale 1ns/1ps
`include "ramp_defines.svh"
module ramp_checker
   import ramp_pkg::*;
#(
   parameter int TICK_CYCLES = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // register bus
   input wire apb_req_t apbReq,
   input wire apb_rsp_t apbRsp,
   // motor side
   input wire logic [31:0] actualSpeed,
   input wire logic quickStopCmd,
   input wire logic [31:0] rampedSetpoint,
   input wire logic overSpeedAlarm,
   input wire logic overSpeedFault,
   input wire logic brakeFault
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [31:0] rampPrev_r;
   int unsigned gapCnt_r;
   logic stWrite;
   function automatic logic [31:0] mag(input logic [31:0] v);
      return v[31] ? -v : v;
   endfunction
   assign stWrite = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite
      & (apbReq.paddr == `OFS_STAT);
   // cycles since the output last moved, saturating so it cannot wrap
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rampPrev_r <= '0;
         gapCnt_r <= TICK_CYCLES;
      end else begin
         rampPrev_r <= rampedSetpoint;
         if (rampedSetpoint != rampPrev_r) gapCnt_r <= 1;
         else if (gapCnt_r < 1000) gapCnt_r <= gapCnt_r + 1;
      end
   end
   ready_wait_a: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=>
      apbRsp.pready) else $error("no ready one cycle after access");
   ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
      else $error("ready held longer than one cycle");
   err_data_a: assert property (apbRsp.pready && apbRsp.pslverr |-> apbRsp.prdata == 0)
      else $error("refused access returned data");
   step_spacing_a: assert property (rampedSetpoint != rampPrev_r |-> gapCnt_r >= TICK_CYCLES)
      else $error("ramp stepped twice within one tick");
   alarm_zero_a: assert property (actualSpeed == 0 |=> !overSpeedAlarm)
      else $error("over-speed alarm at standstill");
   fault_sticky_a: assert property (overSpeedFault && !stWrite |=> overSpeedFault)
      else $error("over-speed fault cleared without write");
   brake_sticky_a: assert property (brakeFault && !stWrite |=> brakeFault)
      else $error("brake fault cleared without write");
   qstop_decay_a: assert property (quickStopCmd [*8] |=>
      mag(rampedSetpoint) <= mag($past(rampedSetpoint))) else $error("speed grew in quick stop");
   limit_range_a: assert property ($signed(rampedSetpoint) <= 210000 &&
      $signed(rampedSetpoint) >= -210000) else $error("setpoint beyond direction limits");
   cover property (apbRsp.pready && apbRsp.pslverr);
   cover property ($rose(overSpeedAlarm));
   cover property ($rose(brakeFault));
endmodule // ramp_checker

bind speed_setpoint_limiter_ramp ramp_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
   .clk_sys(clk_sys), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
   .actualSpeed(actualSpeed), .quickStopCmd(quickStopCmd), .rampedSetpoint(rampedSetpoint),
   .overSpeedAlarm(overSpeedAlarm), .overSpeedFault(overSpeedFault), .brakeFault(brakeFault));

// >>> dv/testbench.sv
// self-checking bench for the speed setpoint limiter and ramp
// assumes design, checker and motor_model compiled first; short tick for speed
`timescale 1ns/1ps
module testbench;
   import ramp_pkg::*;
   localparam int TK = 8;
   logic clk_sys = 0;
   logic resetn = 0;
   apb_req_t apbReq = '0;
   apb_rsp_t apbRsp;
   logic [31:0] setpointIn = '0;
   logic [31:0] dynVal = '0;
   logic [31:0] spdOffset = '0;
   logic [31:0] actualSpeed, rampedSetpoint, rd;
   logic quickStopCmd = 0;
   logic currentLimit = 0;
   logic overSpeedAlarm, overSpeedFault, brakeFault, err;
   int fails = 0;
   int comparisons = 0;
   logic [7:0] rA [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h30};
   logic [31:0] rE [10] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_05DC, 32'h0003_3450,
      32'hFFFC_CBB0, 32'h0000_2710, 32'h0000_2710, 32'h0000_0000, 32'h0000_0000, 32'h0000_0100};
   always #10 clk_sys = ~clk_sys;
   speed_setpoint_limiter_ramp #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys), .resetn(resetn),
      .apbReq(apbReq), .apbRsp(apbRsp), .setpointIn(setpointIn), .minSpeedDyn(dynVal),
      .posLimDyn(dynVal), .negLimDyn(dynVal), .upScaleDyn(dynVal), .dnScaleDyn(dynVal),
      .actualSpeed(actualSpeed), .quickStopCmd(quickStopCmd), .currentLimit(currentLimit),
      .dcLinkHigh(currentLimit), .rampedSetpoint(rampedSetpoint),
      .overSpeedAlarm(overSpeedAlarm), .overSpeedFault(overSpeedFault), .brakeFault(brakeFault));
   motor_model mm (.clk_sys(clk_sys), .rampedSetpoint(rampedSetpoint), .spdOffset(spdOffset),
      .actualSpeed(actualSpeed));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; waits for pready with a bound, never a fixed count
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      if (n >= 20) fails++;
   endtask
   task ticks(input int n);
      repeat (n * TK) @(posedge clk_sys);
   endtask
   task sp(input logic [31:0] v, input int n, input logic [31:0] exp);
      setpointIn <= v;
      ticks(n);
      check(rampedSetpoint, exp);
   endtask
   task final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_sys);
      $display("[ERR] %0t watchdog expired", $time);
      fails++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, rA[i], '0);
         check(rd, rE[i]);
      end
      apb(1'b0, 8'h60, '0);
      check({31'b0, err}, 32'h0000_0001);
      check(rd, 32'h0000_0000);
      $display("test reset values done");
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h14, 32'h0000_000A);
      apb(1'b1, 8'h18, 32'h0000_000A);
      // align to the first step; two ticks on, the check sees one more step of 150 rpm
      setpointIn <= 32'h0000_05DC;
      @(rampedSetpoint);
      ticks(2);
      check(rampedSetpoint, 32'h0000_012C);
      check({31'b0, $signed(rampedSetpoint) < 1500}, 32'h1);
      sp(32'h0000_05DC, 9, 32'h0000_05DC);
      sp(32'h0000_0BB8, 3, 32'h0000_05DC);
      spdOffset <= 32'h0000_00C8;
      repeat (3) @(posedge clk_sys);
      check(overSpeedAlarm, 1'b1);
      apb(1'b1, 8'h00, 32'h0000_0080);
      repeat (2) @(posedge clk_sys);
      check(overSpeedFault, 1'b1);
      spdOffset <= '0;
      apb(1'b1, 8'h38, 32'h0000_0002);
      apb(1'b1, 8'h00, 32'h0000_0000);
      check(overSpeedFault, 1'b0);
      $display("test ramp and clamp done");
      apb(1'b1, 8'h0C, 32'h0000_03E8);
      sp(32'h0000_05DC, 6, 32'h0000_03E8);
      apb(1'b1, 8'h10, 32'hFFFF_FCE0);
      sp(32'hFFFF_F448, 20, 32'hFFFF_FCE0);
      apb(1'b1, 8'h04, 32'h0000_012C);
      sp(32'h0000_0064, 12, 32'h0000_012C);
      dynVal <= 32'h0000_00C8;
      apb(1'b1, 8'h00, 32'h0000_0004);
      sp(32'h0000_0064, 4, 32'h0000_00C8);
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_0000);
      $display("test limits done");
      apb(1'b1, 8'h40, 32'h0000_0190);
      apb(1'b1, 8'h44, 32'h0000_0258);
      sp(32'h0000_01C2, 6, 32'h0000_0190);
      // raised early so the synchroniser has settled before braking starts
      currentLimit <= 1'b1;
      sp(32'h0000_0230, 6, 32'h0000_0258);
      sp(32'h0000_0000, 4, 32'h0000_0258);
      apb(1'b1, 8'h00, 32'h0000_0100);
      ticks(2);
      check(brakeFault, 1'b1);
      currentLimit <= 1'b0;
      apb(1'b1, 8'h00, 32'h0000_0000);
      apb(1'b1, 8'h38, 32'h0000_0004);
      @(posedge clk_sys);
      check(brakeFault, 1'b0);
      $display("test bands and braking done");
      sp(32'h0000_05DC, 10, 32'h0000_03E8);
      quickStopCmd <= 1'b1;
      sp(32'h0000_0000, 3, 32'h0000_0000);
      quickStopCmd <= 1'b0;
      ticks(1);
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h1C, 32'h0000_0004);
      apb(1'b1, 8'h20, 32'h0000_0004);
      setpointIn <= 32'h0000_0384;
      @(rampedSetpoint);
      check(rampedSetpoint, 32'h0000_0025);
      ticks(7);
      check({31'b0, $signed(rampedSetpoint) < 900}, 32'h1);
      sp(32'h0000_0384, 20, 32'h0000_0384);
      // reverse mid-brake: discontinuous smoothing drops the old acceleration
      apb(1'b1, 8'h00, 32'h0000_0003);
      setpointIn <= 32'h0000_0000;
      @(rampedSetpoint);
      @(rampedSetpoint);
      check(rampedSetpoint, 32'h0000_0313);
      setpointIn <= 32'h0000_0384;
      @(rampedSetpoint);
      check(rampedSetpoint, 32'h0000_0339);
      $display("test quick stop and extended done");
      final_report;
   end
endmodule // testbench
